// ===== hw/fpt_pkg.sv
// Package: constants and types of the flash parameter table reader
package fpt_pkg;

    // ****************************************************************
    // Table geometry
    // ****************************************************************
    localparam logic [7:0] TABLE_BASE   = 8'h30;  // First basic parameter byte
    localparam logic [7:0] OFS_DENS_LO  = 8'h34;  // Lowest density byte
    localparam logic [7:0] OFS_DENS_HI  = 8'h37;
    localparam logic [7:0] OFS_QUAD_CYC = 8'h38;  // Quad I/O read cycle counts
    localparam logic [7:0] OFS_QUAD_OP  = 8'h39;  // Quad I/O read instruction
    localparam logic [7:0] OFS_QOUT_CYC = 8'h3A;
    localparam logic [7:0] OFS_QOUT_OP  = 8'h3B;
    localparam logic [7:0] OFS_DOUT_CYC = 8'h3C;
    localparam logic [7:0] OFS_DOUT_OP  = 8'h3D;
    localparam logic [7:0] OFS_DIO_CYC  = 8'h3E;
    localparam logic [7:0] OFS_DIO_OP   = 8'h3F;
    localparam logic [7:0] OFS_QCMD     = 8'h40;
    localparam logic [7:0] OFS_RSV_LO   = 8'h41;
    localparam logic [7:0] OFS_RSV_HI   = 8'h45;
    localparam logic [7:0] OFS_DALL_CYC = 8'h46;
    localparam logic [7:0] OFS_DALL_OP  = 8'h47;

    // ****************************************************************
    // Table contents
    // ****************************************************************
    localparam logic [7:0] VAL_DENS_HI  = 8'h01;
    localparam logic [7:0] VAL_QUAD_CYC = 8'h44;  // 2 mode, 4 dummy
    localparam logic [7:0] VAL_QUAD_OP  = 8'hEB;
    localparam logic [7:0] VAL_QOUT_CYC = 8'h08;  // 0 mode, 8 dummy
    localparam logic [7:0] VAL_QOUT_OP  = 8'h6B;
    localparam logic [7:0] VAL_DOUT_CYC = 8'h08;
    localparam logic [7:0] VAL_DOUT_OP  = 8'h3B;
    localparam logic [7:0] VAL_DIO_CYC  = 8'h80;  // 4 mode, 0 dummy
    localparam logic [7:0] VAL_DIO_OP   = 8'hBB;
    localparam logic [7:0] VAL_QCMD     = 8'hFE;  // Quad command mode bit 4 set
    localparam logic [7:0] VAL_FILL     = 8'hFF;  // Reserved, unsupported, unmapped

    // ****************************************************************
    // Shifter
    // ****************************************************************
    localparam logic [2:0] BIT_LAST  = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [7:0] OFS_STEP  = 8'h01;
    localparam logic       SER_IDLE  = 1'b1;

    typedef enum logic [0:0] {
        ST_IDLE   = 1'b0,
        ST_ACTIVE = 1'b1
    } fpt_state_e;

    // Host-side request group
    typedef struct packed {
        logic       loadAddr;    // Pulse: start a read at startOfs
        logic [7:0] startOfs;
        logic       shiftStrb;   // Pulse: host consumed one bit
    } fpt_req_s;

endpackage

// ===== hw/fpt_param_rom.sv
// Combinational lookup of one parameter table byte by relative offset
`timescale 1ns/100ps
module fpt_param_rom
    import fpt_pkg::*;
(
    // Lookup
    input  wire logic [7:0] addr,
    output logic      [7:0] data
);

    // Fixed table; anything not listed reads as all ones
    always_comb
    begin
        unique case (addr)
            OFS_DENS_HI:  data = VAL_DENS_HI;
            OFS_QUAD_CYC: data = VAL_QUAD_CYC;
            OFS_QUAD_OP:  data = VAL_QUAD_OP;
            OFS_QOUT_CYC: data = VAL_QOUT_CYC;
            OFS_QOUT_OP:  data = VAL_QOUT_OP;
            OFS_DOUT_CYC: data = VAL_DOUT_CYC;
            OFS_DOUT_OP:  data = VAL_DOUT_OP;
            OFS_DIO_CYC:  data = VAL_DIO_CYC;
            OFS_DIO_OP:   data = VAL_DIO_OP;
            OFS_QCMD:     data = VAL_QCMD;
            // Density low bytes, reserved run and dual-all pair all read ones
            default:      data = VAL_FILL;
        endcase
    end

endmodule

// ===== hw/fpt_table_reader.sv
// Serial read-out of the flash parameter table, bytes at relative offsets
// Function
// - Offset 38h reads 44h: quad_io_read two mode, four dummy clocks.
// - Offset 39h reads EBh, the quad_io_read instruction code.
// - Offset 3Ah reads 08h: quad output read, zero mode, eight dummy.
// - Offset 3Bh reads 6Bh, the quad output read instruction code.
// - Offset 3Ch reads 08h: dual output read, zero mode, eight dummy.
// - Offset 3Dh reads 3Bh, the dual output read instruction code.
// - Offset 3Eh reads 80h: dual I/O read, four mode, zero dummy.
// - Offset 3Fh reads BBh, the dual I/O read instruction code.
// - Offset 40h reads FEh: quad_command_mode supported, reserved_bits ones.
// - Offsets 41h to 45h read FFh.
// - Offset 46h reads FFh: dual-all read not offered.
// - Offset 47h, dual-all instruction code, reads FFh.
// - Offsets 34h to 36h read FFh, lower density bytes.
// - Offsets count from table start; basic words begin at 30h.
`timescale 1ns/100ps
module fpt_table_reader
    import fpt_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Host read port
    input  wire logic       selN,
    input  wire fpt_req_s   req,
    // Serial answer
    output logic            serOut_r,
    output logic            byteDone_r,
    // Status
    output logic            active_r,
    output logic      [7:0] curOffset_r,
    output logic      [7:0] curByte_r
);

    // ****************************************************************
    // State
    // ****************************************************************
    fpt_state_e state_r;
    fpt_state_e state_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [2:0] bitCnt_r;
    logic [2:0] bitCnt_nxt;
    logic [7:0] curOffset_nxt;
    logic [7:0] curByte_nxt;
    logic       serOut_nxt;
    logic       byteDone_nxt;
    logic [7:0] romAddr;
    logic [7:0] romData;
    logic [7:0] nextOffset;

    // Offsets beyond FFh wrap; the table never reaches that far
    assign nextOffset = curOffset_r + OFS_STEP;

    // One lookup port shared by load and byte rollover, saving a second table
    assign romAddr = req.loadAddr ? req.startOfs : nextOffset;

    fpt_param_rom u_rom
    (
        .addr (romAddr),
        .data (romData)
    );

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // A load wins over a strobe in the same cycle; select high aborts all
    always_comb
    begin
        state_nxt     = state_r;
        shift_nxt     = shift_r;
        bitCnt_nxt    = bitCnt_r;
        curOffset_nxt = curOffset_r;
        curByte_nxt   = curByte_r;
        serOut_nxt    = serOut_r;
        byteDone_nxt  = 1'b0;
        if (selN)
        begin
            state_nxt  = ST_IDLE;
            serOut_nxt = SER_IDLE;
            bitCnt_nxt = BIT_FIRST;
        end
        else if (req.loadAddr)
        begin
            state_nxt     = ST_ACTIVE;
            curOffset_nxt = req.startOfs;
            curByte_nxt   = romData;
            shift_nxt     = romData;
            serOut_nxt    = romData[7];
            bitCnt_nxt    = BIT_FIRST;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE:
                begin
                    serOut_nxt = SER_IDLE;
                end
                ST_ACTIVE:
                begin
                    if (req.shiftStrb)
                    begin
                        if (bitCnt_r == BIT_LAST)
                        begin
                            // Roll over to the following byte without a gap
                            curOffset_nxt = nextOffset;
                            curByte_nxt   = romData;
                            shift_nxt     = romData;
                            serOut_nxt    = romData[7];
                            bitCnt_nxt    = BIT_FIRST;
                            byteDone_nxt  = 1'b1;
                        end
                        else
                        begin
                            shift_nxt  = {shift_r[6:0], 1'b0};
                            serOut_nxt = shift_r[6];
                            bitCnt_nxt = bitCnt_r + 3'h1;
                        end
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Synchronous reset, every output held at a defined level
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_r     <= ST_IDLE;
            shift_r     <= VAL_FILL;
            bitCnt_r    <= BIT_FIRST;
            curOffset_r <= TABLE_BASE;
            curByte_r   <= VAL_FILL;
            serOut_r    <= SER_IDLE;
            byteDone_r  <= 1'b0;
            active_r    <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            shift_r     <= shift_nxt;
            bitCnt_r    <= bitCnt_nxt;
            curOffset_r <= curOffset_nxt;
            curByte_r   <= curByte_nxt;
            serOut_r    <= serOut_nxt;
            byteDone_r  <= byteDone_nxt;
            active_r    <= (state_nxt == ST_ACTIVE);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Table contents seen at the outputs while a read is running
    property p_quad_cyc;
        @(posedge core_clk) disable iff (!rst_n)
        (active_r && curOffset_r == OFS_QUAD_CYC) |-> curByte_r == VAL_QUAD_CYC;
    endproperty
    a_quad_cyc: assert property (p_quad_cyc) else $error("quad io cycle byte wrong");

    property p_quad_op;
        @(posedge core_clk) disable iff (!rst_n)
        (active_r && curOffset_r == OFS_QUAD_OP) |-> curByte_r == VAL_QUAD_OP;
    endproperty
    a_quad_op: assert property (p_quad_op) else $error("quad io opcode wrong");

    property p_qout;
        @(posedge core_clk) disable iff (!rst_n)
        (active_r && curOffset_r == OFS_QOUT_OP) |-> curByte_r == VAL_QOUT_OP;
    endproperty
    a_qout: assert property (p_qout) else $error("quad output opcode wrong");

    property p_dio_cyc;
        @(posedge core_clk) disable iff (!rst_n)
        (active_r && curOffset_r == OFS_DIO_CYC) |-> curByte_r == VAL_DIO_CYC;
    endproperty
    a_dio_cyc: assert property (p_dio_cyc) else $error("dual io cycle byte wrong");

    property p_qcmd;
        @(posedge core_clk) disable iff (!rst_n)
        (active_r && curOffset_r == OFS_QCMD) |-> curByte_r == VAL_QCMD;
    endproperty
    a_qcmd: assert property (p_qcmd) else $error("quad command byte wrong");

    property p_rsv;
        @(posedge core_clk) disable iff (!rst_n)
        (active_r && curOffset_r >= OFS_RSV_LO && curOffset_r <= OFS_DALL_OP)
            |-> curByte_r == VAL_FILL;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved byte not all ones");

    property p_dens;
        @(posedge core_clk) disable iff (!rst_n)
        (active_r && curOffset_r == OFS_DENS_HI) |-> curByte_r == VAL_DENS_HI;
    endproperty
    a_dens: assert property (p_dens) else $error("density top byte wrong");

    // Eighth strobe moves to the next offset and flags the byte
    property p_incr;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == ST_ACTIVE && !selN && !req.loadAddr && req.shiftStrb
            && bitCnt_r == BIT_LAST)
            |=> byteDone_r && curOffset_r == $past(curOffset_r) + OFS_STEP
                && serOut_r == curByte_r[7];
    endproperty
    a_incr: assert property (p_incr) else $error("offset did not advance");

    // Second bit of a freshly loaded byte follows one strobe later
    property p_bits;
        @(posedge core_clk) disable iff (!rst_n)
        (!selN && req.loadAddr)
            ##1 (!selN && !req.loadAddr && req.shiftStrb)
            |=> serOut_r == curByte_r[6];
    endproperty
    a_bits: assert property (p_bits) else $error("serial bit order wrong");

endmodule

// ===== verification/fpt_host_model.sv
// Host model: issues parameter table reads and collects the returned bytes
`timescale 1ns/100ps
module fpt_host_model
    import fpt_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Serial answer from the table
    input  wire logic       serOut_r,
    input  wire logic       byteDone_r,
    // Request drive
    output logic            selN,
    output fpt_req_s        req
);
    logic [7:0] got [0:31];
    int         doneCnt;

    // ****************************************************************
    // Idle drive and byte counting
    // ****************************************************************
    // Select high and no pulses until a task starts a read
    initial
    begin
        selN    = 1'b1;
        req     = '0;
        doneCnt = 0;
    end

    // Completed bytes; the bench compares differences only
    always @(posedge core_clk)
    begin
        if (byteDone_r === 1'b1)
            doneCnt <= doneCnt + 1;
    end

    // ****************************************************************
    // Read with optional pacing gap and optional abort after cut bits
    // ****************************************************************
    task automatic read_bytes(input logic [7:0] ofs, input int n, input int gap, input int cut);
        logic [7:0] sh;
        sh = 8'h00;
        @(posedge core_clk);
        #1;
        selN         = 1'b0;
        req.loadAddr = 1'b1;
        req.startOfs = ofs;
        @(posedge core_clk);
        #1;
        req.loadAddr = 1'b0;
        for (int b = 0; b < n; b++)
        begin
            for (int k = 0; k < 8; k++)
            begin
                sh            = {sh[6:0], serOut_r};
                req.shiftStrb = 1'b1;
                @(posedge core_clk);
                #1;
                if (cut != 0 && k == cut - 1)
                begin
                    // Drop select mid-byte; the partial byte is lost
                    selN          = 1'b1;
                    req.shiftStrb = 1'b0;
                    return;
                end
                if (gap > 0)
                begin
                    // A slow host leaves the strobe low between bits
                    req.shiftStrb = 1'b0;
                    repeat (gap) @(posedge core_clk);
                    #1;
                end
            end
            got[b] = sh;
        end
        req.shiftStrb = 1'b0;
        selN          = 1'b1;
    endtask

    // Single cycle of load and strobe pulses with select low
    task automatic pulse(input logic ld, input logic st, input logic [7:0] ofs);
        @(posedge core_clk);
        #1;
        selN          = 1'b0;
        req.loadAddr  = ld;
        req.shiftStrb = st;
        req.startOfs  = ofs;
        @(posedge core_clk);
        #1;
        req.loadAddr  = 1'b0;
        req.shiftStrb = 1'b0;
    endtask
endmodule

// ===== verification/fpt_table_reader_bench.sv
// Self-checking bench of the serial parameter table reader
`timescale 1ns/100ps
module fpt_table_reader_bench;
    import fpt_pkg::*;

    logic       core_clk;
    logic       rst_n;
    logic       selN;
    fpt_req_s   req;
    logic       serOut_r;
    logic       byteDone_r;
    logic       active_r;
    logic [7:0] curOffset_r;
    logic [7:0] curByte_r;
    int         err_total;
    int         samples_checked;
    int         n0;

    // ****************************************************************
    // Design, host model and clock
    // ****************************************************************
    fpt_table_reader i_fpt_table_reader (.core_clk(core_clk), .rst_n(rst_n), .selN(selN),
        .req(req), .serOut_r(serOut_r), .byteDone_r(byteDone_r), .active_r(active_r),
        .curOffset_r(curOffset_r), .curByte_r(curByte_r));
    fpt_host_model i_fpt_host_model (.core_clk(core_clk), .rst_n(rst_n), .serOut_r(serOut_r),
        .byteDone_r(byteDone_r), .selN(selN), .req(req));

    // 10 MHz core clock
    always #50 core_clk = ~core_clk;

    // ****************************************************************
    // Expected table and comparison helpers
    // ****************************************************************
    // Everything outside the advertised fields reads all ones
    function automatic logic [7:0] tbl(input logic [7:0] o);
        case (o)
            8'h37: tbl = 8'h01;
            8'h38: tbl = 8'h44;
            8'h39: tbl = 8'hEB;
            8'h3A: tbl = 8'h08;
            8'h3B: tbl = 8'h6B;
            8'h3C: tbl = 8'h08;
            8'h3D: tbl = 8'h3B;
            8'h3E: tbl = 8'h80;
            8'h3F: tbl = 8'hBB;
            8'h40: tbl = 8'hFE;
            default: tbl = 8'hFF;
        endcase
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One byte of the sweep against the expected table
    task automatic chk_tbl(input int b);
        check("table byte", i_fpt_host_model.got[b], tbl(8'h34 + b[7:0]));
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        check("idle bit", {7'h00, serOut_r}, 8'h01);
        check("active", {7'h00, active_r}, 8'h00);
        check("done", {7'h00, byteDone_r}, 8'h00);
        check("reset offset", curOffset_r, 8'h30);
        check("reset byte", curByte_r, 8'hFF);
        $display("reset values done");
    endtask

    // Back-to-back sweep over the whole window, no gap between bytes
    task automatic t_sweep();
        n0 = i_fpt_host_model.doneCnt;
        i_fpt_host_model.read_bytes(8'h34, 20, 0, 0);
        @(posedge core_clk);
        #1;
        for (int b = 0; b < 10; b++)
            chk_tbl(b);
        for (int b = 10; b < 20; b++)
            chk_tbl(b);
        // A host spaces its fast reads by these fields, so decode them as it would
        check("quad io mode", {5'h00, i_fpt_host_model.got[4][7:5]}, 8'h02);
        check("quad io dummy", {3'h0, i_fpt_host_model.got[4][4:0]}, 8'h04);
        check("dual io mode", {5'h00, i_fpt_host_model.got[10][7:5]}, 8'h04);
        check("bytes done", 8'(i_fpt_host_model.doneCnt - n0), 8'd20);
        check("next offset", curOffset_r, 8'h48);
        $display("sweep done");
    endtask

    // Slow host across the offset wrap
    task automatic t_slow_wrap();
        i_fpt_host_model.read_bytes(8'hFE, 2, 2, 0);
        check("wrap byte 0", i_fpt_host_model.got[0], 8'hFF);
        check("wrap byte 1", i_fpt_host_model.got[1], 8'hFF);
        check("wrapped offset", curOffset_r, 8'h00);
        i_fpt_host_model.read_bytes(8'h38, 1, 3, 0);
        check("slow byte", i_fpt_host_model.got[0], 8'h44);
        $display("slow wrap done");
    endtask

    // Abort mid-byte, strobe while idle, load beating a strobe
    task automatic t_pulses();
        i_fpt_host_model.read_bytes(8'h39, 1, 0, 3);
        @(posedge core_clk);
        #1;
        check("abort active", {7'h00, active_r}, 8'h00);
        check("abort bit", {7'h00, serOut_r}, 8'h01);
        i_fpt_host_model.pulse(1'b0, 1'b1, 8'h38);
        check("idle strobe", {7'h00, active_r}, 8'h00);
        i_fpt_host_model.pulse(1'b1, 1'b1, 8'h3F);
        check("load offset", curOffset_r, 8'h3F);
        check("load byte", curByte_r, 8'hBB);
        check("load bit", {7'h00, serOut_r}, 8'h01);
        i_fpt_host_model.pulse(1'b0, 1'b1, 8'h00);
        check("shift bit", {7'h00, serOut_r}, 8'h00);
        $display("pulses done");
    endtask

    // ****************************************************************
    // Main sequence and hang guard
    // ****************************************************************
    initial
    begin
        core_clk        = 1'b0;
        rst_n           = 1'b0;
        err_total       = 0;
        samples_checked = 0;
        repeat (5) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_sweep();
        t_slow_wrap();
        t_pulses();
        finish_test();
    end

    // Cut a hang short after 20000 cycles
    initial
    begin
        #2000000;
        err_total++;
        finish_test();
    end
endmodule
